// file: src/sdv_regs.vh
`ifndef SDV_REGS_VH
`define SDV_REGS_VH
`define SDV_ADDR_CTRL 8'h00
`define SDV_ADDR_LOCKTHR 8'h04
`define SDV_ADDR_STATUS 8'h08
`define SDV_ADDR_ERRCNT 8'h0C
`define SDV_ADDR_INTSTAT 8'h10
`define SDV_ADDR_INTMASK 8'h14
`define SDV_ADDR_NCOFREQ 8'h18
`define SDV_ADDR_LOOPERR 8'h1C
`define SDV_CTRL_RATE 1:0
`define SDV_CTRL_AMB 3:2
`define SDV_CTRL_SWAP 4
`define SDV_CTRL_INVQ 5
`define SDV_CTRL_DSCR 6
`define SDV_CTRL_DIFF 7
`define SDV_CTRL_RST 8'h00
`define SDV_LOCKTHR_RST 10'h040
`define SDV_NCOFREQ_RST 24'h000000
`define SDV_RATE_HALF 2'h0
`define SDV_RATE_3Q 2'h1
`define SDV_RATE_7E 2'h2
`define SDV_RATE_UNC 2'h3
`define SDV_P34_X 7'h05
`define SDV_P34_Y 7'h03
`define SDV_P34_LAST 3'h2
`define SDV_P78_X 7'h51
`define SDV_P78_Y 7'h2F
`define SDV_P78_LAST 3'h6
`define SDV_G1 7'h79
`define SDV_G2 7'h5B
`define SDV_BM_FULL 10'h00E
`define SDV_ERR_MAX 8'hFF
`define SDV_WIN_LAST 10'h3FF
`define SDV_ACT_LIMIT 1024
`define SDV_KP_SHIFT 2
`define SDV_INT_LOCK 0
`define SDV_INT_WIN 1
`define SDV_INT_FAULT 2
`endif

// file: src/sdv_viterbi_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "sdv_regs.vh"

module sdv_activity #(
  parameter LIMIT = `SDV_ACT_LIMIT
) (
  input wire clk,
  input wire rst,
  input wire sample,
  input wire bitIn,
  output reg fault_q
);
  localparam [10:0] LIM = LIMIT[10:0];
  reg last_q;
  reg [10:0] cnt_q;
  // fault when no transition seen for more than LIMIT samples
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_q <= 1'b0;
      cnt_q <= 11'h000;
      fault_q <= 1'b0;
    end
    else if (sample)
    begin
      last_q <= bitIn;
      if (bitIn != last_q)
      begin
        cnt_q <= 11'h000;
        fault_q <= 1'b0;
      end
      else if (cnt_q == LIM)
        fault_q <= 1'b1;
      else
        cnt_q <= cnt_q + 11'h001;
    end
  end
endmodule // sdv_activity

module sdv_viterbi_decoder #(
  parameter ACT_LIMIT = `SDV_ACT_LIMIT
) (
  input wire clk,
  input wire rst,
  input wire [2:0] softI,
  input wire [2:0] softQ,
  input wire softValid,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [1:0] rxData_q,
  output reg rxValid_q,
  output reg rxPair_q,
  output reg lock_q,
  output wire faultI_q,
  output wire faultQ_q,
  output wire faultData_q,
  output reg irq_q,
  output reg [7:0] ncoPhase_q
);
  reg [7:0] ctrl_q;
  reg [9:0] lockThr_q;
  reg [23:0] ncoFreq_q;
  reg [2:0] intStat_q;
  reg [2:0] intMask_q;
  reg [7:0] errCnt_q;
  reg [7:0] errLatch_q;
  reg [9:0] win_q;
  reg [9:0] prevBest_q;
  reg [9:0] spread_q;
  reg [639:0] metric_q;
  reg [5119:0] path_q;
  reg [23:0] buf_q;
  reg [3:0] cnt_q;
  reg [2:0] punPos_q;
  reg [14:0] scr_q;
  reg prevDsc_q;
  reg prevI_q;
  reg prevQ_q;
  reg [2:0] faultPrev_q;
  reg [15:0] integ_q;
  reg [23:0] ncoAcc_q;
  wire [1:0] rate = ctrl_q[`SDV_CTRL_RATE];
  wire uncoded = (rate == `SDV_RATE_UNC);
  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWr = wbReq & wb_we_i;

  // sign matches the hard guess, magnitude adds confidence
  function [3:0] bmf;
    input [2:0] s;
    input e;
    input b;
    begin
      bmf = e ? 4'h0 : ((s[2] == b) ? {2'b01, s[1:0]} : {2'b00, ~s[1:0]});
    end
  endfunction

  function [4:0] sval;
    input [2:0] s;
    begin
      sval = s[2] ? (5'h00 - {2'b00, s[1:0], 1'b1}) : {2'b00, s[1:0], 1'b1};
    end
  endfunction

  // swap and spectral inversion ahead of everything else
  reg [2:0] rotI;
  reg [2:0] rotQ;
  reg [2:0] symA;
  reg [2:0] symB;
  always @*
  begin
    rotI = ctrl_q[`SDV_CTRL_SWAP] ? softQ : softI;
    rotQ = ctrl_q[`SDV_CTRL_SWAP] ? softI : softQ;
    rotQ[2] = rotQ[2] ^ ctrl_q[`SDV_CTRL_INVQ];
    // 90 degree steps, negation flips the sign bit
    case (ctrl_q[`SDV_CTRL_AMB])
      2'h1:
      begin
        symA = {~rotQ[2], rotQ[1:0]};
        symB = rotI;
      end
      2'h2:
      begin
        symA = {~rotI[2], rotI[1:0]};
        symB = {~rotQ[2], rotQ[1:0]};
      end
      2'h3:
      begin
        symA = rotQ;
        symB = {~rotI[2], rotI[1:0]};
      end
      default:
      begin
        symA = rotI;
        symB = rotQ;
      end
    endcase
  end

  // erasure positions from the puncture masks
  reg xP;
  reg yP;
  reg [2:0] punLast;
  reg [1:0] need;
  always @*
  begin
    case (rate)
      `SDV_RATE_3Q:
      begin
        xP = |((`SDV_P34_X >> punPos_q) & 7'h01);
        yP = |((`SDV_P34_Y >> punPos_q) & 7'h01);
        punLast = `SDV_P34_LAST;
      end
      `SDV_RATE_7E:
      begin
        xP = |((`SDV_P78_X >> punPos_q) & 7'h01);
        yP = |((`SDV_P78_Y >> punPos_q) & 7'h01);
        punLast = `SDV_P78_LAST;
      end
      default:
      begin
        xP = 1'b1;
        yP = 1'b1;
        punLast = 3'h0;
      end
    endcase
    need = {1'b0, xP} + {1'b0, yP};
  end
  wire stepGo = ~uncoded & (cnt_q >= {2'b00, need});
  wire [2:0] symX = buf_q[2:0];
  wire [2:0] symY = xP ? buf_q[5:3] : buf_q[2:0];

  // symbols queue until a full decoder step can be taken
  reg [23:0] bufD;
  reg [3:0] cntD;
  always @*
  begin
    bufD = buf_q;
    cntD = cnt_q;
    if (stepGo)
    begin
      bufD = buf_q >> ({need, 1'b0} + {1'b0, need});
      cntD = cnt_q - {2'b00, need};
    end
    // pairs beyond capacity are dropped; the front end runs far below clk
    // both code symbols of one strobe queue together
    if (softValid && !uncoded && cntD <= 4'h6)
    begin
      bufD[cntD * 3 +: 6] = {symB, symA};
      cntD = cntD + 4'h2;
    end
  end

  // four branch metrics, index {first expected, second expected}
  reg [15:0] bmV;
  reg [2:0] i2;
  always @*
  begin
    bmV = 16'h0000;
    for (i2 = 3'h0; i2 < 3'h4; i2 = i2 + 3'h1)
      bmV[i2 * 4 +: 4] = bmf(symX, ~xP, i2[1]) + bmf(symY, ~yP, i2[0]);
  end

  reg [639:0] metricD;
  reg [5119:0] pathD;
  reg [6:0] k;
  reg [5:0] p0;
  reg [5:0] p1;
  reg [1:0] c0;
  reg [1:0] c1;
  reg [9:0] m0;
  reg [9:0] m1;
  reg [9:0] dd;
  always @*
  begin
    metricD = metric_q;
    pathD = path_q;
    p0 = 6'h00;
    p1 = 6'h00;
    c0 = 2'h0;
    c1 = 2'h0;
    m0 = 10'h000;
    m1 = 10'h000;
    dd = 10'h000;
    for (k = 7'h00; k < 7'h40; k = k + 7'h01)
    begin
      p0 = {k[4:0], 1'b0};
      p1 = {k[4:0], 1'b1};
      c0 = {^({k[5], p0} & `SDV_G1), ^({k[5], p0} & `SDV_G2)};
      c1 = {^({k[5], p1} & `SDV_G1), ^({k[5], p1} & `SDV_G2)};
      m0 = metric_q[p0 * 10 +: 10] + {6'h00, bmV[c0 * 4 +: 4]};
      m1 = metric_q[p1 * 10 +: 10] + {6'h00, bmV[c1 * 4 +: 4]};
      // modular compare; spread stays well inside half the metric range
      dd = m1 - m0;
      metricD[k * 10 +: 10] = dd[9] ? m0 : m1;
      // survivor path exchange, oldest bit at the top
      pathD[k * 80 +: 80] = {(dd[9] ? path_q[p0 * 80 +: 79] : path_q[p1 * 80 +: 79]), k[5]};
    end
  end

  // best and worst metric for output and synchronisation
  reg [5:0] bestIdx;
  reg [9:0] bestM;
  reg [9:0] minM;
  reg [9:0] vv;
  reg [9:0] db;
  reg [9:0] dm;
  reg [6:0] j;
  always @*
  begin
    bestIdx = 6'h00;
    bestM = metric_q[9:0];
    minM = metric_q[9:0];
    vv = 10'h000;
    db = 10'h000;
    dm = 10'h000;
    for (j = 7'h01; j < 7'h40; j = j + 7'h01)
    begin
      vv = metric_q[j * 10 +: 10];
      db = vv - bestM;
      dm = vv - minM;
      if (!db[9] && db != 10'h000)
      begin
        bestM = vv;
        bestIdx = j[5:0];
      end
      if (dm[9])
        minM = vv;
    end
  end
  wire [9:0] bestInc = bestM - prevBest_q;
  wire vitBit = path_q[bestIdx * 80 + 79];
  wire dsc = ctrl_q[`SDV_CTRL_DSCR] ? (vitBit ^ scr_q[13] ^ scr_q[14]) : vitBit;
  wire diffOut = ctrl_q[`SDV_CTRL_DIFF] ? (dsc ^ prevDsc_q) : dsc;

  // Costas phase detector on signed soft values
  wire [4:0] vI = sval(rotI);
  wire [4:0] vQ = sval(rotQ);
  wire [5:0] pe = (rotI[2] ? (6'h00 - {vQ[4], vQ}) : {vQ[4], vQ})
    - (rotQ[2] ? (6'h00 - {vI[4], vI}) : {vI[4], vI});
  wire [15:0] filt = {{8{pe[5]}}, pe, 2'b00} + integ_q;
  wire [23:0] ncoD = ncoAcc_q + ncoFreq_q + {{8{filt[15]}}, filt};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      buf_q <= 24'h000000;
      cnt_q <= 4'h0;
      punPos_q <= 3'h0;
      metric_q <= {640{1'b0}};
      path_q <= {5120{1'b0}};
      scr_q <= 15'h0000;
      prevDsc_q <= 1'b0;
      prevI_q <= 1'b0;
      prevQ_q <= 1'b0;
      // seeded one clean branch below the zero start, else the first step counts as an error
      prevBest_q <= 10'h000 - `SDV_BM_FULL;
      spread_q <= 10'h000;
      errCnt_q <= 8'h00;
      errLatch_q <= 8'h00;
      win_q <= 10'h000;
      lock_q <= 1'b0;
      rxData_q <= 2'h0;
      rxValid_q <= 1'b0;
      rxPair_q <= 1'b0;
      integ_q <= 16'h0000;
      ncoAcc_q <= 24'h000000;
      ncoPhase_q <= 8'h00;
    end
    else
    begin
      buf_q <= bufD;
      cnt_q <= cntD;
      ncoAcc_q <= ncoD;
      ncoPhase_q <= ncoD[23:16];
      rxValid_q <= 1'b0;
      if (softValid)
        integ_q <= integ_q + {{10{pe[5]}}, pe};
      // uncoded sign bits always differentially decoded
      if (uncoded && softValid)
      begin
        prevI_q <= symA[2];
        prevQ_q <= symB[2];
        rxData_q <= {symA[2] ^ prevI_q, symB[2] ^ prevQ_q};
        rxPair_q <= 1'b1;
        rxValid_q <= 1'b1;
      end
      if (stepGo)
      begin
        punPos_q <= (punPos_q >= punLast) ? 3'h0 : punPos_q + 3'h1;
        metric_q <= metricD;
        path_q <= pathD;
        scr_q <= {scr_q[13:0], vitBit};
        prevDsc_q <= dsc;
        prevBest_q <= bestM;
        spread_q <= bestM - minM;
        // lock while spread reaches the threshold
        lock_q <= ((bestM - minM) >= lockThr_q);
        // decoded bit is the block output
        rxData_q <= {1'b0, diffOut};
        rxPair_q <= 1'b0;
        rxValid_q <= 1'b1;
        // a step gaining less than a clean branch counts as an error
        win_q <= win_q + 10'h001;
        if (win_q == `SDV_WIN_LAST)
        begin
          errLatch_q <= errCnt_q;
          errCnt_q <= (bestInc < `SDV_BM_FULL) ? 8'h01 : 8'h00;
        end
        else if (bestInc < `SDV_BM_FULL && errCnt_q != `SDV_ERR_MAX)
          errCnt_q <= errCnt_q + 8'h01;
      end
    end
  end

  sdv_activity #(.LIMIT(ACT_LIMIT)) actI (
    .clk(clk),
    .rst(rst),
    .sample(softValid),
    .bitIn(symA[2]),
    .fault_q(faultI_q)
  );
  sdv_activity #(.LIMIT(ACT_LIMIT)) actQ (
    .clk(clk),
    .rst(rst),
    .sample(softValid),
    .bitIn(symB[2]),
    .fault_q(faultQ_q)
  );
  sdv_activity #(.LIMIT(ACT_LIMIT)) actD (
    .clk(clk),
    .rst(rst),
    .sample(stepGo),
    .bitIn(dsc),
    .fault_q(faultData_q)
  );

  wire [2:0] faults = {faultData_q, faultQ_q, faultI_q};
  wire lockNext = stepGo ? ((bestM - minM) >= lockThr_q) : lock_q;
  wire [2:0] evt = {|(faults & ~faultPrev_q), stepGo && win_q == `SDV_WIN_LAST, lockNext != lock_q};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    begin
      merge = (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}})
        | (nw & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
    end
  endfunction

  reg [31:0] rdMux;
  always @*
  begin
    case (wb_adr_i & 8'hFC)
      `SDV_ADDR_CTRL: rdMux = {24'h000000, ctrl_q};
      `SDV_ADDR_LOCKTHR: rdMux = {22'h000000, lockThr_q};
      `SDV_ADDR_STATUS: rdMux = {6'h00, spread_q, 12'h000, faults, lock_q};
      `SDV_ADDR_ERRCNT: rdMux = {24'h000000, errLatch_q};
      `SDV_ADDR_INTSTAT: rdMux = {29'h00000000, intStat_q};
      `SDV_ADDR_INTMASK: rdMux = {29'h00000000, intMask_q};
      `SDV_ADDR_NCOFREQ: rdMux = {8'h00, ncoFreq_q};
      `SDV_ADDR_LOOPERR: rdMux = {16'h0000, integ_q};
      default: rdMux = 32'h00000000;
    endcase
  end

  wire [31:0] wm = merge(32'h00000000, 32'hFFFFFFFF, wb_sel_i);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `SDV_CTRL_RST;
      lockThr_q <= `SDV_LOCKTHR_RST;
      ncoFreq_q <= `SDV_NCOFREQ_RST;
      intStat_q <= 3'h0;
      intMask_q <= 3'h0;
      faultPrev_q <= 3'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdMux : 32'h00000000;
      faultPrev_q <= faults;
      // set wins over a write-one clear in the same cycle
      if (wbWr && (wb_adr_i & 8'hFC) == `SDV_ADDR_INTSTAT)
        intStat_q <= (intStat_q & ~wb_dat_i[2:0]) | evt;
      else
        intStat_q <= intStat_q | evt;
      irq_q <= |((intStat_q | evt) & intMask_q);
      if (wbWr)
      begin
        case (wb_adr_i & 8'hFC)
          `SDV_ADDR_CTRL: ctrl_q <= (ctrl_q & ~wm[7:0]) | (wb_dat_i[7:0] & wm[7:0]);
          `SDV_ADDR_LOCKTHR: lockThr_q <= (lockThr_q & ~wm[9:0]) | (wb_dat_i[9:0] & wm[9:0]);
          `SDV_ADDR_INTMASK: intMask_q <= (intMask_q & ~wm[2:0]) | (wb_dat_i[2:0] & wm[2:0]);
          // oscillator centre step written by software
          `SDV_ADDR_NCOFREQ: ncoFreq_q <= (ncoFreq_q & ~wm[23:0]) | (wb_dat_i[23:0] & wm[23:0]);
          default: ;
        endcase
      end
    end
  end
endmodule // sdv_viterbi_decoder
`default_nettype wire

// file: tb/sdv_front_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdv_regs.vh"
module sdv_front_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic coded,
  input wire logic bitI,
  input wire logic bitQ,
  output logic [2:0] softI,
  output logic [2:0] softQ,
  output logic softValid
);
  logic [5:0] encState_q;
  logic prevI_q;
  logic prevQ_q;
  logic signI;
  logic signQ;
  always_comb
  begin
    signI = coded ? ^({bitI, encState_q} & `SDV_G1) : bitI ^ prevI_q;
    signQ = coded ? ^({bitI, encState_q} & `SDV_G2) : bitQ ^ prevQ_q;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      encState_q <= 6'h00;
      prevI_q <= 1'h0;
      prevQ_q <= 1'h0;
      softI <= 3'h0;
      softQ <= 3'h0;
      softValid <= 1'h0;
    end
    else if (send)
    begin
      encState_q <= {bitI, encState_q[5:1]};
      prevI_q <= signI;
      prevQ_q <= signQ;
      softI <= {signI, 2'h3};
      softQ <= {signQ, 2'h3};
      softValid <= 1'h1;
    end
    else
    begin
      // released lines toggle so a stale sample cannot pass
      softI <= ~softI;
      softQ <= ~softQ;
      softValid <= 1'h0;
    end
  end
endmodule // sdv_front_end
`default_nettype wire

// file: tb/sdv_viterbi_decoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sdv_checker #(
  parameter ACT_LIMIT = 1024
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic softValid,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] rxData_q,
  input wire logic rxValid_q,
  input wire logic rxPair_q,
  input wire logic lock_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data idle");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:5] != 3'h0 |-> wb_dat_o == 32'h0) else $error("unmapped data");
  a_coded_bit_clear: assert property (rxValid_q && !rxPair_q |-> !rxData_q[1]) else $error("coded upper bit");
  a_data_held: assert property (!rxValid_q |-> $stable(rxData_q)) else $error("data moved");
  a_pair_from_input: assert property (rxValid_q && rxPair_q |-> $past(softValid)) else $error("uncoded late");
  a_lock_on_step: assert property ($changed(lock_q) |-> rxValid_q) else $error("lock moved off a step");
endmodule // sdv_checker
bind sdv_viterbi_decoder sdv_checker #(.ACT_LIMIT(ACT_LIMIT)) chkInst (.clk, .rst, .softValid, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rxData_q, .rxValid_q, .rxPair_q, .lock_q);
`default_nettype wire

// file: tb/soft_decision_viterbi_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdv_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module soft_decision_viterbi_decoder_test;
  logic clk = '0;
  logic rst = '1;
  logic wb_cyc_i = '0;
  logic wb_stb_i = '0;
  logic wb_we_i = '0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic send = '0;
  logic coded = '0;
  logic bitI = '0;
  logic bitQ = '0;
  logic wantZero = '0;
  logic [2:0] softI, softQ;
  logic [1:0] rxData_q;
  logic [1:0] expNow;
  logic [7:0] ncoPhase_q;
  logic [31:0] wb_dat_o, rdat;
  logic softValid, wb_ack_o, rxValid_q, rxPair_q, lock_q, faultI_q, faultQ_q, faultData_q, irq_q;
  logic [31:0] seed = 32'h0000DF4F;
  logic [1:0] expQ [$];
  int fails = 0;
  int checks_done = 0;
  int nOut = 0;
  sdv_viterbi_decoder #(.ACT_LIMIT(8)) DUT (.clk, .rst, .softI, .softQ, .softValid, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxData_q, .rxValid_q, .rxPair_q, .lock_q, .faultI_q,
    .faultQ_q, .faultData_q, .irq_q, .ncoPhase_q);
  sdv_front_end model (.clk, .rst, .send, .coded, .bitI, .bitQ, .softI, .softQ, .softValid);
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic reset();
    rst <= 1'h1;
    expQ.delete();
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit got;
    got = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(posedge clk);
      got = wb_ack_o === 1'h1;
    end
    if (!got)
    begin
      fails++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk);
  endtask
  task automatic sym(input logic i, input logic q);
    send <= 1'h1;
    bitI <= i;
    bitQ <= q;
    @(posedge clk);
    send <= 1'h0;
    @(posedge clk);
  endtask
  // results are judged mid-cycle, clear of the launching edge
  always @(negedge clk)
  begin
    if (rxValid_q === 1'h1)
    begin
      if (rxPair_q === 1'h1)
      begin
        // an empty queue gives an unknown note, which the compare counts as a miss
        expNow = (expQ.size() > 0) ? expQ.pop_front() : 2'hX;
        `CHK(rxData_q, expNow)
      end
      else
      begin
        nOut++;
        if (wantZero) `CHK(rxData_q, 2'h0)
      end
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [7:0] ph;
    reset();
    wb(1'h0, `SDV_ADDR_CTRL, 32'h0, 4'hF);
    `CHK(rdat[7:0], `SDV_CTRL_RST)
    wb(1'h0, `SDV_ADDR_LOCKTHR, 32'h0, 4'hF);
    `CHK(rdat[9:0], `SDV_LOCKTHR_RST)
    wb(1'h0, 8'h20, 32'h0, 4'hF);
    `CHK(rdat, 32'h0)
    wb(1'h1, `SDV_ADDR_NCOFREQ, 32'h00A5C3F1, 4'h3);
    wb(1'h0, `SDV_ADDR_NCOFREQ, 32'h0, 4'hF);
    `CHK(rdat[23:0], 24'h00C3F1)
    // idle lines carry equal I and Q, so the loop adds nothing and the phase steps by the centre alone
    wb(1'h1, `SDV_ADDR_NCOFREQ, 32'h00010000, 4'hF);
    ph = ncoPhase_q;
    repeat (16) @(posedge clk);
    `CHK(8'(ncoPhase_q - ph), 8'h10)
    $display("registers done");
    for (int sw = 0; sw < 2; sw++)
    begin
      reset();
      coded <= 1'h0;
      wb(1'h1, `SDV_ADDR_CTRL, {27'h0, sw[0], 2'h0, `SDV_RATE_UNC}, 4'hF);
      repeat (40)
      begin
        r = rnd();
        expQ.push_back(sw ? {r[1], r[0]} : {r[0], r[1]});
        sym(r[0], r[1]);
      end
      repeat (4) @(posedge clk);
      `CHK(expQ.size(), 0)
      `CHK(faultI_q, 1'h0)
      $display("uncoded done");
    end
    reset();
    coded <= 1'h1;
    wb(1'h1, `SDV_ADDR_LOCKTHR, 32'h10, 4'hF);
    wb(1'h1, `SDV_ADDR_INTMASK, 32'h1, 4'hF);
    for (int st = 0; st < 16 && lock_q !== 1'h1; st++)
    begin
      wb(1'h1, `SDV_ADDR_NCOFREQ, st << 12, 4'hF);
      repeat (4) sym(1'h0, 1'h0);
    end
    repeat (150) sym(1'h0, 1'h0);
    wantZero <= 1'h1;
    repeat (950) sym(1'h0, 1'h0);
    `CHK(lock_q, 1'h1)
    `CHK(faultI_q, 1'h1)
    `CHK(faultQ_q, 1'h1)
    `CHK(faultData_q, 1'h1)
    `CHK(irq_q, 1'h1)
    wb(1'h0, `SDV_ADDR_ERRCNT, 32'h0, 4'hF);
    `CHK(rdat[7:0], 8'h00)
    wb(1'h0, `SDV_ADDR_INTSTAT, 32'h0, 4'hF);
    `CHK(rdat[2:0], 3'h7)
    wb(1'h1, `SDV_ADDR_INTSTAT, 32'h1, 4'hF);
    `CHK(irq_q, 1'h0)
    wb(1'h1, `SDV_ADDR_INTMASK, 32'h4, 4'hF);
    `CHK(irq_q, 1'h1)
    wb(1'h1, `SDV_ADDR_LOCKTHR, 32'h3FF, 4'hF);
    repeat (5) sym(1'h0, 1'h0);
    `CHK(lock_q, 1'h0)
    $display("coded done");
    for (int k = 0; k < 2; k++)
    begin
      wb(1'h1, `SDV_ADDR_CTRL, {30'h0, k ? `SDV_RATE_7E : `SDV_RATE_3Q}, 4'hF);
      nOut = 0;
      repeat (40) sym(1'h0, 1'h0);
      repeat (10) @(posedge clk);
      `CHK(nOut >= (k ? 68 : 58) && nOut <= (k ? 70 : 60), 1'h1)
    end
    $display("punctured done");
    complete_run();
  end
endmodule // soft_decision_viterbi_decoder_test
`default_nettype wire
